/* rt_sacw_consts.vh */
// Constants for the subaddress control word register bank
`ifndef RT_SACW_CONSTS_VH
`define RT_SACW_CONSTS_VH

// Register offsets
`define SACW_OFS 8'h04
`define BUF_CFG_OFS 8'h10
`define IRQ_STAT_OFS 8'h14
`define IRQ_CLR_OFS 8'h18
`define IRQ_EN_OFS 8'h1c

// Control word field positions (word bit numbers)
`define CTRL_LSB 8
`define GLOBAL_SEL_BIT 15
`define TX_EOM_BIT 14
`define TX_ROLL_BIT 13
`define TX_SIZE_HI 12
`define TX_SIZE_LO 10
`define RX_EOM_BIT 9
`define RX_ROLL_BIT 8

// Buffer configuration register bits
`define CFG_ENH_MODE_BIT 0
`define CFG_ENH_BUF_BIT 1
`define CFG_DOUBLE_BUFFER_ENABLE_BIT 2
`define CFG_CIRC_BIT 3

// Interrupt status, clear and enable bits
`define IRQ_TX_EOM_BIT 0
`define IRQ_TX_ROLL_BIT 1
`define IRQ_RX_EOM_BIT 2
`define IRQ_RX_ROLL_BIT 3

// Reset values
`define SACW_RST 8'h00
`define BUF_CFG_RST 4'h0
`define IRQ_EN_RST 4'h0
`define IRQ_STAT_RST 4'h0

// Circular buffer sizing
`define CIRC_BASE_WORDS 14'h0080
`define SIZE_SINGLE 3'h0
`define SIZE_GLOBAL_CIRC 3'h7

// Receive buffering modes
`define RX_MODE_SINGLE 2'h0
`define RX_MODE_DOUBLE 2'h1
`define RX_MODE_CIRC 2'h2

`endif

/* buf_size_decode.v */
// Decoder from a three-bit buffer size field to buffer kind and length
`timescale 1ns/10ps
`include "rt_sacw_consts.vh"

module buf_size_decode (
	// Size field
	input wire [2:0] size_field,
	// Decoded buffer
	output reg circular,
	output reg [13:0] words
);

	// Code one gives 128 words and each higher code doubles the circular length
	always @* begin
		circular = (size_field != `SIZE_SINGLE);
		if (size_field == `SIZE_SINGLE) begin
			words = 14'h0000;
		end else begin
			words = `CIRC_BASE_WORDS << (size_field - 3'h1);
		end
	end

endmodule // buf_size_decode

/* rt_subaddr_buffer_control.v */
// Subaddress control word register, buffer mode decode and event requests
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "rt_sacw_consts.vh"

module rt_subaddr_buffer_control #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// Host register port
	input wire [ADDR_W-1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_q,
	// Message engine: terminal state and lookup table load
	input wire rt_active,
	input wire lut_load,
	input wire [15:0] lut_word,
	// Receive size field from the low half of the control word
	input wire [2:0] rx_size_field,
	// Message engine events
	input wire msg_done,
	input wire msg_is_tx,
	input wire buf_rollover,
	input wire rollover_is_tx,
	// Decoded transmit buffering
	output reg tx_circular_q,
	output reg [13:0] tx_circ_words_q,
	// Decoded receive buffering
	output reg [1:0] rx_mode_q,
	output reg rx_global_q,
	output reg [13:0] rx_circ_words_q,
	// Interrupt
	output reg irq_q
);

	// Stored upper half of the control word
	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	// Buffer configuration bits
	reg [3:0] cfg_q;
	reg [3:0] cfg_d;
	// Interrupt status and enable
	reg [3:0] irq_stat_q;
	reg [3:0] irq_stat_d;
	reg [3:0] irq_en_q;
	reg [3:0] irq_en_d;

	// Address decode strobes
	wire hit_sacw;
	wire hit_cfg;
	wire hit_stat;
	wire hit_clr;
	wire hit_en;

	// Field views of the control word
	wire global_buffering_select;
	wire tx_end_message_irq_enable;
	wire tx_rollover_irq_enable;
	wire [2:0] tx_buffer_size_field;
	wire rx_end_message_irq_enable;
	wire rx_rollover_irq_enable;

	// Field views of the configuration register
	wire enhanced_mode;
	wire enhanced_terminal_buffering_enable;
	wire double_buffer_enable;
	wire circular_buffer_enable;

	// Qualified event requests
	reg [3:0] evt_req;

	// Decoder results
	wire tx_circ_dec;
	wire [13:0] tx_words_dec;
	wire rx_circ_dec;
	wire [13:0] rx_words_dec;

	// Next values of decoded outputs
	reg [1:0] rx_mode_d;
	reg rx_global_d;
	reg [13:0] rx_words_d;
	reg [15:0] rdata_d;
	wire [3:0] clr_bits;
	wire per_sa_ok;

	// Address decode; unmapped addresses read zero and ignore writes
	assign hit_sacw = (reg_addr == `SACW_OFS);
	assign hit_cfg = (reg_addr == `BUF_CFG_OFS);
	assign hit_stat = (reg_addr == `IRQ_STAT_OFS);
	assign hit_clr = (reg_addr == `IRQ_CLR_OFS);
	assign hit_en = (reg_addr == `IRQ_EN_OFS);

	// Control word field extraction
	assign global_buffering_select =
		ctrl_q[`GLOBAL_SEL_BIT-`CTRL_LSB];
	assign tx_end_message_irq_enable = ctrl_q[`TX_EOM_BIT-`CTRL_LSB];
	assign tx_rollover_irq_enable = ctrl_q[`TX_ROLL_BIT-`CTRL_LSB];
	assign tx_buffer_size_field =
		ctrl_q[`TX_SIZE_HI-`CTRL_LSB:`TX_SIZE_LO-`CTRL_LSB];
	assign rx_end_message_irq_enable = ctrl_q[`RX_EOM_BIT-`CTRL_LSB];
	assign rx_rollover_irq_enable = ctrl_q[`RX_ROLL_BIT-`CTRL_LSB];

	// Configuration field extraction
	assign enhanced_mode = cfg_q[`CFG_ENH_MODE_BIT];
	assign enhanced_terminal_buffering_enable = cfg_q[`CFG_ENH_BUF_BIT];
	assign double_buffer_enable = cfg_q[`CFG_DOUBLE_BUFFER_ENABLE_BIT];
	assign circular_buffer_enable = cfg_q[`CFG_CIRC_BIT];

	// Control word update
	always @* begin
		ctrl_d = ctrl_q;
		if (rt_active) begin
			if (lut_load) begin
				ctrl_d = lut_word[15:`CTRL_LSB];
			end
		end else if (reg_wr && hit_sacw) begin
			ctrl_d = reg_wdata[15:`CTRL_LSB];
		end
	end

	// Configuration and enable writes; these are host-owned at all times
	always @* begin
		cfg_d = cfg_q;
		irq_en_d = irq_en_q;
		if (reg_wr && hit_cfg) begin
			cfg_d = reg_wdata[3:0];
		end
		if (reg_wr && hit_en) begin
			irq_en_d = reg_wdata[3:0];
		end
	end

	// Qualify each event by its own enable bit only
	always @* begin
		evt_req = 4'h0;
		evt_req[`IRQ_TX_EOM_BIT] =
			msg_done & msg_is_tx & tx_end_message_irq_enable;
		evt_req[`IRQ_TX_ROLL_BIT] =
			buf_rollover & rollover_is_tx & tx_rollover_irq_enable;
		evt_req[`IRQ_RX_EOM_BIT] =
			msg_done & ~msg_is_tx & rx_end_message_irq_enable;
		evt_req[`IRQ_RX_ROLL_BIT] =
			buf_rollover & ~rollover_is_tx & rx_rollover_irq_enable;
	end

	// Clear strobe bits from the write-only clear register
	assign clr_bits = (reg_wr && hit_clr) ? reg_wdata[3:0] : 4'h0;

	// requests into pending bits
	// A request arriving with its clear keeps the bit set, so none is lost
	always @* begin
		irq_stat_d = (irq_stat_q & ~clr_bits) | evt_req;
	end

	// Transmit decode of the size field
	buf_size_decode u_tx_dec (
		.size_field(tx_buffer_size_field),
		.circular(tx_circ_dec),
		.words(tx_words_dec)
	);

	// Receive decode of the size field from the low half
	buf_size_decode u_rx_dec (
		.size_field(rx_size_field),
		.circular(rx_circ_dec),
		.words(rx_words_dec)
	);

	// Per-subaddress buffering needs both enhanced controls
	assign per_sa_ok = enhanced_mode & enhanced_terminal_buffering_enable;

	// Receive buffering mode selection
	always @* begin
		rx_mode_d = `RX_MODE_SINGLE;
		rx_global_d = global_buffering_select;
		rx_words_d = 14'h0000;
		if (global_buffering_select) begin
			if (rx_size_field == `SIZE_SINGLE) begin
				rx_mode_d = `RX_MODE_DOUBLE;
			end else if (rx_size_field == `SIZE_GLOBAL_CIRC) begin
				// Length comes from another configuration register
				rx_mode_d = `RX_MODE_CIRC;
			end else begin
				rx_mode_d = `RX_MODE_SINGLE;
			end
		end else if (per_sa_ok) begin
			if (rx_circ_dec) begin
				if (circular_buffer_enable) begin
					rx_mode_d = `RX_MODE_CIRC;
					rx_words_d = rx_words_dec;
				end
			end else if (double_buffer_enable) begin
				rx_mode_d = `RX_MODE_DOUBLE;
			end
		end
	end

	// Read mux; data is valid only in the cycle after the strobe
	always @* begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			if (hit_sacw) begin
				rdata_d = {ctrl_q, 8'h00};
			end else if (hit_cfg) begin
				rdata_d = {12'h000, cfg_q};
			end else if (hit_stat) begin
				rdata_d = {12'h000, irq_stat_q};
			end else if (hit_en) begin
				rdata_d = {12'h000, irq_en_q};
			end else begin
				rdata_d = 16'h0000;
			end
		end
	end

	// Register state
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_q <= `SACW_RST;
			cfg_q <= `BUF_CFG_RST;
			irq_stat_q <= `IRQ_STAT_RST;
			irq_en_q <= `IRQ_EN_RST;
		end else begin
			ctrl_q <= ctrl_d;
			cfg_q <= cfg_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
		end
	end

	// Registered outputs; decode lags the stored word by one cycle
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata_q <= 16'h0000;
			tx_circular_q <= 1'b0;
			tx_circ_words_q <= 14'h0000;
			rx_mode_q <= `RX_MODE_SINGLE;
			rx_global_q <= 1'b0;
			rx_circ_words_q <= 14'h0000;
			irq_q <= 1'b0;
		end else begin
			reg_rdata_q <= rdata_d;
			tx_circular_q <= tx_circ_dec;
			tx_circ_words_q <= tx_words_dec;
			rx_mode_q <= rx_mode_d;
			rx_global_q <= rx_global_d;
			rx_circ_words_q <= rx_words_d;
			// Level output from current pending and enable bits
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

endmodule // rt_subaddr_buffer_control

/* sacw_asserts.sv */
// Checker for the subaddress control word block
`timescale 1ns/10ps
module sacw_asserts #(
	parameter ADDR_W = 8
) (
	// Clock, reset and host port
	input wire ref_clk,
	input wire rst_n,
	input wire [ADDR_W-1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata_q,
	// Engine side
	input wire rt_active,
	input wire lut_load,
	input wire [15:0] lut_word,
	input wire [2:0] rx_size_field,
	input wire msg_done,
	input wire buf_rollover,
	// Decoded outputs
	input wire tx_circular_q,
	input wire [13:0] tx_circ_words_q,
	input wire [1:0] rx_mode_q,
	input wire rx_global_q,
	input wire irq_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Control word write and a quiet host cycle
	wire cw_wr = reg_wr && reg_addr == 8'h04;
	wire quiet = !reg_wr && !lut_load;
	function [13:0] words(input [2:0] s);
		words = (s == 3'h0) ? 14'h0 : 14'h0040 << s;
	endfunction
	sequence idle_wr;
		cw_wr && !rt_active ##1 quiet;
	endsequence
	rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0)
		else $error("read data outside read slot");
	wr_readback_a: assert property (cw_wr && !rt_active ##1 quiet ##1
		reg_rd && reg_addr == 8'h04 && !lut_load |=>
		reg_rdata_q == {$past(reg_wdata[15:8], 3), 8'h00})
		else $error("idle write not read back");
	locked_a: assert property (cw_wr && rt_active && !lut_load ##1 quiet
		|=> $stable(rx_global_q) && $stable(tx_circ_words_q))
		else $error("write took effect while active");
	lut_load_a: assert property (rt_active && lut_load |=> ##1
		rx_global_q == $past(lut_word[15], 2))
		else $error("engine load not applied");
	tx_words_a: assert property (idle_wr |=>
		tx_circ_words_q == words($past(reg_wdata[12:10], 2)))
		else $error("tx buffer length wrong");
	tx_kind_a: assert property (idle_wr |=>
		tx_circular_q == ($past(reg_wdata[12:10], 2) != 3'h0))
		else $error("tx buffer kind wrong");
	rx_global_a: assert property (cw_wr && !rt_active && reg_wdata[15]
		##1 quiet && (rx_size_field == 3'h0 || rx_size_field == 3'h7)
		|=> rx_mode_q == ($past(rx_size_field) == 3'h0 ? 2'h1 : 2'h2))
		else $error("global rx buffering wrong");
	irq_cause_a: assert property ($rose(irq_q) |->
		$past(msg_done || buf_rollover, 2) ||
		$past(reg_wr && reg_addr == 8'h1c, 2))
		else $error("interrupt without cause");
	irq_clear_a: assert property (reg_wr && reg_addr == 8'h18 &&
		reg_wdata[3:0] == 4'hf && !msg_done && !buf_rollover |=> ##1 !irq_q)
		else $error("interrupt not cleared");
endmodule // sacw_asserts

/* testbench.sv */
// Self-checking bench for the subaddress control word block
`timescale 1ns/10ps
module testbench;
	reg ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg rt_active = 1'b0, lut_load = 1'b0, msg_done = 1'b0;
	reg msg_is_tx = 1'b0, buf_rollover = 1'b0, rollover_is_tx = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [15:0] reg_wdata = 16'h0, lut_word = 16'h0, w;
	reg [2:0] rx_size_field = 3'h0;
	reg [9:0] e;
	wire [15:0] reg_rdata_q;
	wire tx_circular_q, rx_global_q, irq_q;
	wire [13:0] tx_circ_words_q, rx_circ_words_q;
	wire [1:0] rx_mode_q;
	integer bad_count = 0, checks = 0, i, k;
	// Rows: global bit, config, rx size, expected rx mode
	localparam [79:0] TAB = {10'b0_0011_000_00, 10'b0_0011_011_00,
		10'b1_0000_000_01, 10'b1_0000_111_10,
		10'b1_0000_011_00, 10'b0_1011_011_10, 10'b0_0111_000_01,
		10'b0_1100_011_00};
	localparam [63:0] EN = {16'h0100, 16'h0200, 16'h2000, 16'h4000};
	// Device under test
	rt_subaddr_buffer_control #(.ADDR_W(8)) uut (.ref_clk(ref_clk),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.rt_active(rt_active), .lut_load(lut_load), .lut_word(lut_word),
		.rx_size_field(rx_size_field), .msg_done(msg_done),
		.msg_is_tx(msg_is_tx), .buf_rollover(buf_rollover),
		.rollover_is_tx(rollover_is_tx), .tx_circular_q(tx_circular_q),
		.tx_circ_words_q(tx_circ_words_q), .rx_mode_q(rx_mode_q),
		.rx_global_q(rx_global_q), .rx_circ_words_q(rx_circ_words_q),
		.irq_q(irq_q));
	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	function [13:0] words(input [2:0] s);
		words = (s == 3'h0) ? 14'h0 : 14'h0040 << s;
	endfunction
	task check(input string nm, input [15:0] seen, input [15:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Strobes drop one edge later, so calls never overlap in a step
	task wr(input [7:0] a, input [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, input [15:0] x);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 check("rdata", reg_rdata_q, x);
	endtask
	task load(input [15:0] d);
		@(posedge ref_clk);
		lut_load <= 1'b1;
		lut_word <= d;
		@(posedge ref_clk);
		lut_load <= 1'b0;
	endtask
	// Events 0..3: tx end, tx wrap, rx end, rx wrap
	task ev(input integer n);
		@(posedge ref_clk);
		msg_done <= !n[0];
		buf_rollover <= n[0];
		msg_is_tx <= n < 2;
		rollover_is_tx <= n < 2;
		@(posedge ref_clk);
		msg_done <= 1'b0;
		buf_rollover <= 1'b0;
	endtask
	task tick;
		@(posedge ref_clk);
		#1;
	endtask
	task close_out;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'h5161d976));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++)
			rd(8'(i * 4), 16'h0);
		// Every tx size code, random other bits
		for (i = 0; i < 8; i++) begin
			w = 16'($urandom);
			w[12:10] = i[2:0];
			wr(8'h04, w);
			rd(8'h04, {w[15:8], 8'h00});
			check("tx_words", tx_circ_words_q, words(i[2:0]));
			check("tx_circ", tx_circular_q, i != 0);
		end
		// First row leaves the per-subaddress enables off; last two leave circular and double off
		for (i = 0; i < 8; i++) begin
			e = TAB[i*10 +: 10];
			wr(8'h10, {12'h0, e[8:5]});
			rx_size_field <= e[4:2];
			wr(8'h04, {e[9], 15'h0});
			tick;
			check("rx_mode", rx_mode_q, e[1:0]);
			check("rx_glob", rx_global_q, e[9]);
			check("rx_words", rx_circ_words_q,
				(e[1] && !e[9]) ? words(e[4:2]) : 14'h0);
			rd(8'h10, {12'h0, e[8:5]});
		end
		// Active terminal: engine loads win, host writes are dropped
		@(posedge ref_clk);
		rt_active <= 1'b1;
		for (i = 0; i < 4; i++) begin
			w = 16'($urandom);
			load(w);
			wr(8'h04, ~w);
			rd(8'h04, {w[15:8], 8'h00});
			check("rx_glob", rx_global_q, w[15]);
		end
		@(posedge ref_clk);
		rt_active <= 1'b0;
		for (k = 0; k < 4; k++) begin
			wr(8'h1c, 16'h0);
			wr(8'h04, 16'h0);
			ev(k);
			rd(8'h14, 16'h0);
			wr(8'h04, EN[k*16 +: 16]);
			ev(k);
			rd(8'h14, 16'h1 << k);
			check("irq_mask", irq_q, 1'b0);
			wr(8'h1c, 16'h1 << k);
			tick;
			check("irq_on", irq_q, 1'b1);
			wr(8'h18, 16'hf);
			tick;
			check("irq_clr", irq_q, 1'b0);
			rd(8'h14, 16'h0);
		end
		close_out;
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		bad_count = bad_count + 1;
		close_out;
	end
endmodule // testbench
bind rt_subaddr_buffer_control sacw_asserts #(.ADDR_W(ADDR_W)) chk (.*);
